// *** brtc_pkg.sv ***
// Constants, types and helper functions for the BCD clock with battery-backed RAM.
`default_nettype none
package brtc_pkg;
   // Memory geometry and register window.
   localparam int ADDR_W = 19;
   localparam int MEM_WORDS = 512 * 1024;
   localparam int REG_COUNT = 8;
   localparam logic [18:0] REG_BASE = 19'h7fff8;
   // Register index within the window (low three address bits).
   localparam logic [2:0] IDX_CENT = 3'h0;
   localparam logic [2:0] IDX_SEC = 3'h1;
   localparam logic [2:0] IDX_MIN = 3'h2;
   localparam logic [2:0] IDX_HOUR = 3'h3;
   localparam logic [2:0] IDX_DAY = 3'h4;
   localparam logic [2:0] IDX_DATE = 3'h5;
   localparam logic [2:0] IDX_MONTH = 3'h6;
   localparam logic [2:0] IDX_YEAR = 3'h7;
   // Control and flag bit positions.
   localparam int WFRZ_BIT = 7;
   localparam int RFRZ_BIT = 6;
   localparam int OSC_BIT = 7;
   localparam int FT_BIT = 6;
   localparam int BF_BIT = 7;
   localparam int SEC_LSB = 0;
   // Bits of each register that belong to the counter.
   localparam logic [7:0] CENT_MASK = 8'h3f;
   localparam logic [7:0] SEC_MASK = 8'h7f;
   localparam logic [7:0] HOUR_MASK = 8'h3f;
   localparam logic [7:0] DAY_MASK = 8'h07;
   localparam logic [7:0] DATE_MASK = 8'h3f;
   localparam logic [7:0] MONTH_MASK = 8'h1f;
   localparam logic [7:0] YEAR_MASK = 8'hff;
   // BCD limits of each field.
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] SEC_LAST = 8'h59;
   localparam logic [7:0] HOUR_LAST = 8'h23;
   localparam logic [7:0] DAY_LAST = 8'h07;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] CENT_LAST = 8'h39;
   localparam logic [7:0] FEB = 8'h02;
   localparam logic [7:0] APR = 8'h04;
   localparam logic [7:0] JUN = 8'h06;
   localparam logic [7:0] SEP = 8'h09;
   localparam logic [7:0] NOV = 8'h11;
   localparam logic [7:0] DATE_28 = 8'h28;
   localparam logic [7:0] DATE_29 = 8'h29;
   localparam logic [7:0] DATE_30 = 8'h30;
   localparam logic [7:0] DATE_31 = 8'h31;
   // Timing: clock rate and the derived cycle counts.
   localparam int CLK_PERIOD_NS = 20;
   localparam int NS_PER_S = 1000000000;
   localparam int CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int FT_FREQ_HZ = 512;
   localparam int FT_HALF_CYCLES = CLK_HZ / (2 * FT_FREQ_HZ);
   // Counter time; century sits in the low byte so byte i is register i.
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
      logic [7:0] century;
   } brtc_time_s;
   // Host memory bus pins; the three strobes are active low.
   typedef struct packed {
      logic [18:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [7:0] data;
   } brtc_bus_s;
   localparam brtc_time_s TIME_RESET = '{year: 8'h00, month: 8'h01, date: 8'h01,
      day: 8'h01, hour: 8'h00, minute: 8'h00, second: 8'h00, century: 8'h20};
   // Counter bits of register idx.
   function automatic logic [7:0] field_mask(input logic [2:0] idx);
      unique case (idx)
         IDX_CENT: field_mask = CENT_MASK;
         IDX_SEC, IDX_MIN: field_mask = SEC_MASK;
         IDX_HOUR: field_mask = HOUR_MASK;
         IDX_DAY: field_mask = DAY_MASK;
         IDX_DATE: field_mask = DATE_MASK;
         IDX_MONTH: field_mask = MONTH_MASK;
         IDX_YEAR: field_mask = YEAR_MASK;
      endcase
   endfunction
   // BCD increment that wraps from last back to first.
   function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
      input logic [7:0] first);
      if (v == last)
         bcd_step = first;
      else if (v[3:0] == 4'h9)
         bcd_step = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_step = v + 8'h01;
   endfunction
   // A two-digit BCD value divisible by four.
   function automatic logic bcd_div4(input logic [7:0] v);
      bcd_div4 = (v[1:0] + {v[4], 1'b0}) == 2'h0;
   endfunction
   // Last date of the month, leap rule by year and century.
   function automatic logic [7:0] month_last(input brtc_time_s t);
      if (t.month == FEB)
         month_last = (bcd_div4(t.year) && (t.year != BCD_ZERO || bcd_div4(t.century)))
            ? DATE_29 : DATE_28;
      else if (t.month == APR || t.month == JUN || t.month == SEP || t.month == NOV)
         month_last = DATE_30;
      else
         month_last = DATE_31;
   endfunction
endpackage
`default_nettype wire

// *** brtc_calendar.sv ***
// Internal BCD time counter with load port.
`timescale 1ns/1ps
`default_nettype none
module brtc_calendar
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Advance and load controls.
   input wire logic tick_i,
   input wire logic load_i,
   input wire brtc_pkg::brtc_time_s load_time_i,
   // Running time.
   output brtc_pkg::brtc_time_s time_o
);
   brtc_pkg::brtc_time_s next_time;

   // Carry chain; each field only moves when every field below it wraps, except that date steps on the hour wrap alongside day and day carries nowhere.
   // BCD carry chain
   always_comb
   begin
      next_time = time_o;
      if (load_i)
         next_time = load_time_i;
      else if (tick_i)
      begin
         next_time.second = brtc_pkg::bcd_step(time_o.second, brtc_pkg::SEC_LAST,
            brtc_pkg::BCD_ZERO);
         if (time_o.second == brtc_pkg::SEC_LAST)
         begin
            next_time.minute = brtc_pkg::bcd_step(time_o.minute, brtc_pkg::SEC_LAST,
               brtc_pkg::BCD_ZERO);
            if (time_o.minute == brtc_pkg::SEC_LAST)
            begin
               next_time.hour = brtc_pkg::bcd_step(time_o.hour, brtc_pkg::HOUR_LAST,
                  brtc_pkg::BCD_ZERO);
               if (time_o.hour == brtc_pkg::HOUR_LAST)
               begin
                  next_time.day = brtc_pkg::bcd_step(time_o.day, brtc_pkg::DAY_LAST,
                     brtc_pkg::BCD_ONE);
                  next_time.date = brtc_pkg::bcd_step(time_o.date,
                     brtc_pkg::month_last(time_o), brtc_pkg::BCD_ONE);
                  if (time_o.date == brtc_pkg::month_last(time_o))
                  begin
                     next_time.month = brtc_pkg::bcd_step(time_o.month,
                        brtc_pkg::MONTH_LAST, brtc_pkg::BCD_ONE);
                     if (time_o.month == brtc_pkg::MONTH_LAST)
                     begin
                        next_time.year = brtc_pkg::bcd_step(time_o.year,
                           brtc_pkg::YEAR_LAST, brtc_pkg::BCD_ZERO);
                        if (time_o.year == brtc_pkg::YEAR_LAST)
                           next_time.century = brtc_pkg::bcd_step(time_o.century,
                              brtc_pkg::CENT_LAST, brtc_pkg::BCD_ZERO);
                     end
                  end
               end
            end
         end
      end
   end

   // The counter register itself.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         time_o <= brtc_pkg::TIME_RESET;
      else
         time_o <= next_time;
   end

   // Seconds wrap from 59 to 00.
   sec_wrap_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      tick_i && !load_i && time_o.second == brtc_pkg::SEC_LAST |=>
         time_o.second == brtc_pkg::BCD_ZERO)
      else $error("seconds did not wrap to zero");

   // A non-leap February ends on the 28th.
   feb_end_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      tick_i && !load_i && time_o.month == brtc_pkg::FEB && time_o.year == 8'h01
         && time_o.date == brtc_pkg::DATE_28 && time_o.hour == brtc_pkg::HOUR_LAST
         && time_o.minute == brtc_pkg::SEC_LAST && time_o.second == brtc_pkg::SEC_LAST
      |=> time_o.date == brtc_pkg::BCD_ONE && time_o.month == 8'h03)
      else $error("non-leap February did not end on the 28th");
endmodule
`default_nettype wire

// *** brtc_nvram.sv ***
// Clock with battery-backed RAM behind an asynchronous byte-wide memory port.
`timescale 1ns/1ps
`default_nettype none
module brtc_nvram
#(
   parameter int MEM_WORDS = brtc_pkg::MEM_WORDS,
   parameter int SEC_CYCLES = brtc_pkg::SEC_CYCLES,
   parameter int FT_HALF_CYCLES = brtc_pkg::FT_HALF_CYCLES
)
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Host memory bus pins.
   input wire brtc_pkg::brtc_bus_s host_i,
   // Supply and battery monitors.
   input wire logic power_fail_threshold_i,
   input wire logic battery_ok_flag_i,
   // Data lines driven back to the host.
   output logic [7:0] dq_o,
   output logic dq_oe_o
);
   localparam int SEC_W = $clog2(SEC_CYCLES);
   localparam int FT_W = $clog2(FT_HALF_CYCLES);
   localparam logic [SEC_W-1:0] SEC_END = SEC_W'(SEC_CYCLES - 1);
   localparam logic [FT_W-1:0] FT_END = FT_W'(FT_HALF_CYCLES - 1);
   localparam logic [63:0] RESET_BITS = 64'(brtc_pkg::TIME_RESET);

   logic [7:0] mem [MEM_WORDS];
   logic [7:0] vis [brtc_pkg::REG_COUNT];
   logic rd_en;
   logic wr_act;
   logic in_regs;
   logic [2:0] acc_idx;
   logic wr_q;
   logic [18:0] wr_addr;
   logic [7:0] wr_data;
   logic commit;
   logic commit_reg;
   logic rfrz;
   logic wfrz;
   logic wfrz_q;
   logic osc_stop;
   logic ft_en;
   logic load;
   logic refresh;
   logic tick;
   logic [SEC_W-1:0] sec_cnt;
   logic [FT_W-1:0] ft_cnt;
   logic ft_wave;
   logic [7:0] reg_val;
   logic [63:0] load_bits;
   logic [63:0] cal_bits;
   logic [63:0] vis_bits;
   brtc_pkg::brtc_time_s cal_time;
   brtc_pkg::brtc_time_s load_time;

   // Access decode; power fail deselects everything.
   always_comb
   begin
      rd_en = !power_fail_threshold_i && !host_i.ce_n && !host_i.oe_n && host_i.we_n;
      wr_act = !power_fail_threshold_i && !host_i.ce_n && !host_i.we_n;
      in_regs = host_i.addr >= brtc_pkg::REG_BASE;
      acc_idx = host_i.addr[2:0];
   end

   // Control flags held in the visible registers.
   always_comb
   begin
      rfrz = vis[brtc_pkg::IDX_CENT][brtc_pkg::RFRZ_BIT];
      wfrz = vis[brtc_pkg::IDX_CENT][brtc_pkg::WFRZ_BIT];
      osc_stop = vis[brtc_pkg::IDX_SEC][brtc_pkg::OSC_BIT];
      ft_en = vis[brtc_pkg::IDX_DAY][brtc_pkg::FT_BIT];
   end

   // Capture address and data while the write strobe is low; data is only
   // guaranteed just before the end of write, so the last sample is used.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         wr_q <= 1'b0;
         wr_addr <= '0;
         wr_data <= 8'h00;
      end
      else
      begin
         wr_q <= wr_act;
         if (wr_act)
         begin
            wr_addr <= host_i.addr;
            wr_data <= host_i.data;
         end
      end
   end

   // Commit at the end of the strobe; a power fail mid-write drops it.
   // commit at strobe end
   assign commit = wr_q && !wr_act && !power_fail_threshold_i;
   assign commit_reg = commit && wr_addr >= brtc_pkg::REG_BASE;

   // RAM array write; it has no reset because its contents are retained.
   always_ff @(posedge sys_clk_i)
   begin
      if (commit && !commit_reg)
         mem[wr_addr] <= wr_data;
   end

   // Edge of the set-freeze bit, seen one cycle late so the clearing write
   // has already landed its century digits in the visible register.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         wfrz_q <= 1'b0;
      else
         wfrz_q <= wfrz;
   end

   assign load = wfrz_q && !wfrz;
   assign refresh = !rfrz && !wfrz && !wfrz_q;

   // Time value handed to the counter: counter bits of the visible registers.
   always_comb
   begin
      load_bits = '0;
      for (int i = 0; i < brtc_pkg::REG_COUNT; i++)
         load_bits[i*8 +: 8] = vis[i] & brtc_pkg::field_mask(3'(i));
   end
   assign load_time = brtc_pkg::brtc_time_s'(load_bits);
   assign cal_bits = 64'(cal_time);

   // Visible registers: refreshed from the counter every unfrozen cycle, so
   // a cleared read-freeze brings all of them up to date on the next edge.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < brtc_pkg::REG_COUNT; i++)
            vis[i] <= RESET_BITS[i*8 +: 8];
      end
      else
      begin
         for (int i = 0; i < brtc_pkg::REG_COUNT; i++)
         begin
            if (refresh)
               vis[i] <= (vis[i] & ~brtc_pkg::field_mask(3'(i)))
                  | (cal_bits[i*8 +: 8] & brtc_pkg::field_mask(3'(i)));
            if (commit_reg && wr_addr[2:0] == 3'(i))
               vis[i] <= wr_data;
         end
      end
   end

   // One-second prescaler; it holds while the oscillator is stopped and
   // restarts when a new time is loaded.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         sec_cnt <= '0;
      else if (load)
         sec_cnt <= '0;
      else if (!osc_stop)
         sec_cnt <= (sec_cnt == SEC_END) ? '0 : sec_cnt + 1'b1;
   end

   assign tick = !osc_stop && sec_cnt == SEC_END;

   // Test square wave; it also needs the oscillator.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         ft_cnt <= '0;
         ft_wave <= 1'b0;
      end
      else if (!osc_stop)
      begin
         ft_cnt <= (ft_cnt == FT_END) ? '0 : ft_cnt + 1'b1;
         if (ft_cnt == FT_END)
            ft_wave <= ~ft_wave;
      end
   end

   brtc_calendar u_cal
   (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick),
      .load_i(load),
      .load_time_i(load_time),
      .time_o(cal_time)
   );

   // Register read value with the read-only and test overrides.
   always_comb
   begin
      reg_val = vis[acc_idx];
      if (acc_idx == brtc_pkg::IDX_DAY)
         reg_val[brtc_pkg::BF_BIT] = battery_ok_flag_i;
      if (acc_idx == brtc_pkg::IDX_SEC && ft_en && !osc_stop)
         reg_val[brtc_pkg::SEC_LSB] = ft_wave;
   end

   // Data lines: sampled each cycle, so a held read tracks the wave.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         dq_o <= 8'h00;
         dq_oe_o <= 1'b0;
      end
      else
      begin
         dq_oe_o <= rd_en;
         dq_o <= in_regs ? reg_val : mem[host_i.addr];
      end
   end

   // Helper view of the visible counter bits for the checks below.
   always_comb
   begin
      vis_bits = '0;
      for (int i = 0; i < brtc_pkg::REG_COUNT; i++)
         vis_bits[i*8 +: 8] = vis[i] & brtc_pkg::field_mask(3'(i));
   end

   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   pf_float_a: assert property (
      power_fail_threshold_i |=> !dq_oe_o)
      else $error("data lines driven during power fail");

   read_drive_a: assert property (
      rd_en |=> dq_oe_o ##0 (!$past(in_regs) || $past(acc_idx) != brtc_pkg::IDX_YEAR
         || dq_o == $past(vis[brtc_pkg::IDX_YEAR])))
      else $error("read did not drive the addressed byte");

   idle_float_a: assert property (
      !rd_en |=> !dq_oe_o)
      else $error("data lines driven without a read");

   freeze_hold_a: assert property (
      rfrz && $past(rfrz) && !$past(commit_reg) |-> $stable(vis_bits))
      else $error("visible time moved during read freeze");

   refresh_copy_a: assert property (
      refresh && !commit_reg |=> vis_bits == $past(cal_bits))
      else $error("visible registers not refreshed from counter");

   set_load_a: assert property (
      load |=> 64'(cal_time) == $past(load_bits))
      else $error("counter not loaded when set-freeze cleared");

   osc_halt_a: assert property (
      osc_stop && !load |=> $stable(cal_bits) && $stable(sec_cnt))
      else $error("timekeeping advanced while oscillator stopped");

   battery_read_a: assert property (
      rd_en && in_regs && acc_idx == brtc_pkg::IDX_DAY |=>
         dq_o[brtc_pkg::BF_BIT] == $past(battery_ok_flag_i))
      else $error("battery flag not reported on read");

   ft_toggle_a: assert property (
      !osc_stop && ft_cnt == FT_END |=> ft_wave != $past(ft_wave))
      else $error("test wave missed its toggle");
endmodule
`default_nettype wire

// *** brtc_host.sv ***
// Host processor model driving the asynchronous byte-wide memory bus.
`timescale 1ns/1ps
`default_nettype none
module brtc_host
(
   // Clock.
   input wire logic sys_clk_i,
   // Data returned by the device.
   input wire logic [7:0] dq_i,
   input wire logic dq_oe_i,
   // Bus pins to the device.
   output brtc_pkg::brtc_bus_s bus_o
);
   // The idle bus shows the inverse of the last byte, so a stale value never passes for data.
   initial
   begin
      bus_o = '{addr: 19'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, data: 8'hff};
   end
   // strobed byte write
   // Strobe low for one edge, released before the commit edge; returns on that edge.
   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      bus_o = '{addr: a, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, data: d};
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      bus_o.ce_n = 1'b1;
      bus_o.we_n = 1'b1;
      bus_o.data = ~d;
      @(posedge sys_clk_i);
   endtask
   // held read
   // Address and strobes stay put for n cycles past the answer; toggles of line 0 are counted.
   task automatic rd(input logic [18:0] a, input int n, output logic [7:0] d, output logic oe,
      output int tg);
      logic prev;
      @(negedge sys_clk_i);
      bus_o.addr = a;
      bus_o.ce_n = 1'b0;
      bus_o.oe_n = 1'b0;
      bus_o.we_n = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      d = dq_i;
      oe = dq_oe_i;
      tg = 0;
      repeat (n)
      begin
         prev = dq_i[0];
         @(negedge sys_clk_i);
         if (dq_i[0] !== prev)
            tg++;
      end
      bus_o.ce_n = 1'b1;
      bus_o.oe_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** brtc_nvram_tb.sv ***
// Self-checking testbench for the BCD clock with battery-backed RAM.
`timescale 1ns/1ps
`default_nettype none
module brtc_nvram_tb;
   logic sys_clk_i, nrst_i, pf, bat, oe;
   logic [7:0] dq, d, s1, s2;
   logic dq_oe;
   brtc_pkg::brtc_bus_s bus;
   int err_total = 0, cmp_count = 0, seed = 52336, tg;
   logic [18:0] ra [16];
   logic [7:0] rv [16];
   // Start and expected {century, year, month, date} across a 23:59:59 rollover.
   logic [63:0] cases [5] = '{64'h21000228_21000301, 64'h20000228_20000229,
      64'h20240229_20240301, 64'h20991231_21000101, 64'h20230430_20230501};
   // Short second and test-wave counts keep the run brief.
   brtc_nvram #(.SEC_CYCLES(16), .FT_HALF_CYCLES(4)) u_dut (.sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i), .host_i(bus), .power_fail_threshold_i(pf), .battery_ok_flag_i(bat),
      .dq_o(dq), .dq_oe_o(dq_oe));
   brtc_host u_host (.sys_clk_i(sys_clk_i), .dq_i(dq), .dq_oe_i(dq_oe), .bus_o(bus));
   // Clock generator.
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [18:0] adr(input logic [2:0] idx);
      adr = brtc_pkg::REG_BASE + {16'h0000, idx};
   endfunction
   task automatic print_verdict();
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Compares the drive flag together with the data byte.
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic rchk(input string nm, input logic [18:0] a, input logic [7:0] e,
      input logic [7:0] m);
      u_host.rd(a, 0, d, oe, tg);
      chk(nm, {1'b1, e & m}, {oe, d & m});
   endtask
   // Loads a time of 23:59:59 on day 7 through the set-freeze sequence.
   task automatic set_time(input logic [31:0] t);
      u_host.wr(adr(brtc_pkg::IDX_CENT), 8'h80 | t[31:24]);
      u_host.wr(adr(brtc_pkg::IDX_SEC), 8'h59);
      u_host.wr(adr(brtc_pkg::IDX_MIN), 8'h59);
      u_host.wr(adr(brtc_pkg::IDX_HOUR), 8'h23);
      u_host.wr(adr(brtc_pkg::IDX_DAY), 8'h07);
      u_host.wr(adr(brtc_pkg::IDX_DATE), t[7:0]);
      u_host.wr(adr(brtc_pkg::IDX_MONTH), t[15:8]);
      u_host.wr(adr(brtc_pkg::IDX_YEAR), t[23:16]);
      u_host.wr(adr(brtc_pkg::IDX_CENT), t[31:24]);
   endtask
   // A hang is cut short here and counted as a mismatch.
   initial
   begin
      repeat (100000) @(posedge sys_clk_i);
      err_total++;
      print_verdict();
   end
   // Main sequence.
   initial
   begin
      nrst_i = 1'b0;
      pf = 1'b0;
      bat = 1'b1;
      repeat (12) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      nrst_i = 1'b1;
      rchk("century", adr(brtc_pkg::IDX_CENT), 8'h20, 8'hff);
      rchk("year", adr(brtc_pkg::IDX_YEAR), 8'h00, 8'hff);
      rchk("month", adr(brtc_pkg::IDX_MONTH), 8'h01, 8'hff);
      rchk("day", adr(brtc_pkg::IDX_DAY), 8'h81, 8'hff);
      repeat (2) @(negedge sys_clk_i);
      chk("release", 9'h000, {dq_oe, 8'h00});
      // Random RAM bytes, the byte just below the clock window first.
      foreach (ra[i])
      begin
         ra[i] = (i == 0) ? 19'h7fff7 : 19'($random(seed)) & 19'h7fff7;
         rv[i] = 8'($random(seed));
         u_host.wr(ra[i], rv[i]);
      end
      foreach (ra[i])
         rchk("ram", ra[i], rv[i], 8'hff);
      // Rollovers through month ends, leap years and the century.
      foreach (cases[i])
      begin
         set_time(cases[i][63:32]);
         repeat (20) @(negedge sys_clk_i);
         u_host.wr(adr(brtc_pkg::IDX_SEC), 8'h80);
         rchk("century", adr(brtc_pkg::IDX_CENT), cases[i][31:24], 8'hff);
         rchk("year", adr(brtc_pkg::IDX_YEAR), cases[i][23:16], 8'hff);
         rchk("month", adr(brtc_pkg::IDX_MONTH), cases[i][15:8], 8'hff);
         rchk("date", adr(brtc_pkg::IDX_DATE), cases[i][7:0], 8'hff);
         rchk("day", adr(brtc_pkg::IDX_DAY), 8'h81, 8'hff);
         rchk("hour", adr(brtc_pkg::IDX_HOUR), 8'h00, 8'hff);
         rchk("minute", adr(brtc_pkg::IDX_MIN), 8'h00, 8'hff);
      end
      repeat (40) @(negedge sys_clk_i);
      rchk("stopped", adr(brtc_pkg::IDX_SEC), 8'h80, 8'hff);
      // Read freeze holds the view while the counter keeps going.
      u_host.wr(adr(brtc_pkg::IDX_SEC), 8'h00);
      u_host.wr(adr(brtc_pkg::IDX_CENT), 8'h60);
      u_host.rd(adr(brtc_pkg::IDX_SEC), 0, s1, oe, tg);
      repeat (40) @(negedge sys_clk_i);
      rchk("frozen", adr(brtc_pkg::IDX_SEC), s1, 8'hff);
      u_host.wr(adr(brtc_pkg::IDX_CENT), 8'h20);
      u_host.rd(adr(brtc_pkg::IDX_SEC), 0, s2, oe, tg);
      chk("advanced", 9'h001, {8'h00, s2 >= s1 + 8'h02});
      // Test wave on line 0: eight toggles in 32 cycles, none once stopped.
      u_host.wr(adr(brtc_pkg::IDX_DAY), 8'h41);
      u_host.rd(adr(brtc_pkg::IDX_SEC), 32, d, oe, tg);
      chk("wave", 9'h008, 9'(tg));
      u_host.wr(adr(brtc_pkg::IDX_SEC), 8'h80);
      u_host.rd(adr(brtc_pkg::IDX_SEC), 32, d, oe, tg);
      chk("no wave", 9'h000, 9'(tg));
      // Spare bits are plain storage; battery flag ignores writes.
      u_host.wr(adr(brtc_pkg::IDX_MONTH), 8'he1);
      rchk("spare", adr(brtc_pkg::IDX_MONTH), 8'he0, 8'he0);
      @(negedge sys_clk_i);
      bat = 1'b0;
      u_host.wr(adr(brtc_pkg::IDX_DAY), 8'h81);
      rchk("battery", adr(brtc_pkg::IDX_DAY), 8'h00, 8'h80);
      // Power fail blocks both writes and reads.
      @(negedge sys_clk_i);
      pf = 1'b1;
      u_host.wr(ra[0], ~rv[0]);
      u_host.rd(ra[0], 0, d, oe, tg);
      chk("pf read", 9'h000, {oe, 8'h00});
      @(negedge sys_clk_i);
      pf = 1'b0;
      bat = 1'b1;
      rchk("pf kept", ra[0], rv[0], 8'hff);
      print_verdict();
   end
endmodule
`default_nettype wire
